// >>> logic/pio_pkg.sv
//Contract
//[R1] Two parallel units exist, each with ports A, B, C and a control register; the first sits at E4 to E7.
//[R2] The second unit sits at E8 to EB, and each unit answers only to its own chip select.
//[R3] Address bits 00, 01, 10 pick ports A, B, C and 11 picks the write-only control register, which must not be read.
//[R4] With select low a read drives the chosen byte and a write loads it; with select high the data bus floats.
//[R5] A high reset input clears every unit register, control included, so all ports become inputs.
//[R6] The first unit's ports support every mode and the external interrupt, each port set as input or output.
//[R7] The second unit's ports support only the basic mode, each port still set as input or output.
//[R8] Unit chip selects come from interrupt acknowledge, the I/O qualifier, the top address bit and two decode memory bits.
//[R9] All board interrupt sources have equal priority and merge onto one CPU interrupt, with two off-board sources.
//[R10] Module addresses F0 to F7 assert module select 0 and F8 to FF assert module select 1.
//[R11] Select, address and strobes are sampled on the clock, and a write commits when its strobe is seen rising.
package pio_pkg;
	localparam logic [7:0] UNIT0_PORT_A_DATA = 8'h00_E4;
	localparam logic [7:0] UNIT0_PORT_B_DATA = 8'h00_E5;
	localparam logic [7:0] UNIT0_PORT_C_DATA = 8'h00_E6;
	localparam logic [7:0] UNIT0_CONTROL = 8'h00_E7;
	localparam logic [7:0] UNIT1_PORT_A_DATA = 8'h00_E8;
	localparam logic [7:0] UNIT1_PORT_B_DATA = 8'h00_E9;
	localparam logic [7:0] UNIT1_PORT_C_DATA = 8'h00_EA;
	localparam logic [7:0] UNIT1_CONTROL = 8'h00_EB;
	localparam logic [7:0] MODULE0_FIRST = 8'h00_F0;
	localparam logic [7:0] MODULE1_FIRST = 8'h00_F8;
	// register select inside a unit
	localparam logic [1:0] SEL_PORT_A = 2'h0;
	localparam logic [1:0] SEL_PORT_B = 2'h1;
	localparam logic [1:0] SEL_PORT_C = 2'h2;
	localparam logic [1:0] SEL_CONTROL = 2'h3;
	// control register fields
	localparam int CTL_A_OUT = 0;
	localparam int CTL_B_OUT = 1;
	localparam int CTL_C_OUT = 2;
	localparam int CTL_MODE_LO = 3;
	localparam int CTL_MODE_HI = 4;
	localparam logic [7:0] CONTROL_RESET = 8'h00_00;
	localparam logic [7:0] PORT_RESET = 8'h00_00;
	localparam logic [1:0] MODE_BASIC = 2'h0;
	localparam logic [1:0] DECODE_UNIT0 = 2'h1;
	localparam logic [1:0] DECODE_UNIT1 = 2'h2;
	localparam logic [1:0] DECODE_NONE = 2'h0;
	localparam int UNIT_PORT_BITS = 24;

	typedef enum logic [2:0] {
		CYC_IDLE = 3'h1,
		CYC_READ = 3'h2,
		CYC_WRITE = 3'h4
	} cycle_state_t;
endpackage

// >>> logic/unit_bus_if.sv
interface unit_bus_if;
	logic wr_commit;
	logic [1:0] wr_sel;
	logic [7:0] wr_data;
	logic rd_active;
	logic [1:0] rd_sel;
	logic [7:0] rd_data;
	logic unit_reset;

	modport ctrl (output wr_commit, output wr_sel, output wr_data, output rd_active, output rd_sel,
		output unit_reset, input rd_data);
	modport unit (input wr_commit, input wr_sel, input wr_data, input rd_active, input rd_sel,
		input unit_reset, output rd_data);
endinterface

// >>> logic/parallel_io_unit.sv
module parallel_io_unit
	import pio_pkg::*;
#(
	parameter bit FULL_MODES = 1'b1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// host side
	unit_bus_if.unit bus,
	// port pins, A in the low byte
	input wire logic [pio_pkg::UNIT_PORT_BITS-1:0] pins_in,
	output logic [pio_pkg::UNIT_PORT_BITS-1:0] pins_out,
	output logic [pio_pkg::UNIT_PORT_BITS-1:0] pins_oe_n,
	// external interrupt strobe and request
	input wire logic strobe_n,
	output logic intr
);
	import pio_pkg::*;

	logic [7:0] port_reg [3];
	logic [7:0] port_next [3];
	logic [7:0] control_reg, control_next;
	logic strobe_prev_reg, strobe_prev_next;
	logic intr_reg, intr_next;
	logic [1:0] mode;
	logic [2:0] out_dir;

	assign mode = control_reg[CTL_MODE_HI:CTL_MODE_LO];
	assign out_dir = {control_reg[CTL_C_OUT], control_reg[CTL_B_OUT], control_reg[CTL_A_OUT]}; // [R6] [R7]

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			port_next[i] = port_reg[i];
		end
		control_next = control_reg;
		if (bus.wr_commit) begin
			if (bus.wr_sel == SEL_CONTROL) begin // [R3]
				control_next = bus.wr_data;
				// basic-only unit cannot leave mode zero
				if (!FULL_MODES) begin // [R7]
					control_next[CTL_MODE_HI:CTL_MODE_LO] = MODE_BASIC;
				end
			end else begin
				port_next[bus.wr_sel] = bus.wr_data; // [R4]
			end
		end
		strobe_prev_next = strobe_n;
		intr_next = intr_reg;
		if (bus.wr_commit && bus.wr_sel == SEL_PORT_A) begin
			intr_next = 1'b0;
		end
		if (bus.rd_active && bus.rd_sel == SEL_PORT_A) begin
			intr_next = 1'b0;
		end
		// set after clear so a coincident strobe wins
		if (FULL_MODES && mode != MODE_BASIC && strobe_prev_reg && !strobe_n) begin // [R6]
			intr_next = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || bus.unit_reset) begin // [R5]
			for (int i = 0; i < 3; i++) begin
				port_reg[i] <= PORT_RESET;
			end
			control_reg <= CONTROL_RESET;
			strobe_prev_reg <= 1'b1;
			intr_reg <= 1'b0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				port_reg[i] <= port_next[i];
			end
			control_reg <= control_next;
			strobe_prev_reg <= strobe_prev_next;
			intr_reg <= intr_next;
		end
	end

	always_comb begin
		bus.rd_data = PORT_RESET;
		for (int i = 0; i < 3; i++) begin
			pins_out[i*8 +: 8] = port_reg[i];
			pins_oe_n[i*8 +: 8] = {8{~out_dir[i]}};
			if (bus.rd_sel == 2'(i)) begin
				// input ports show the pins, output ports the latch
				bus.rd_data = out_dir[i] ? port_reg[i] : pins_in[i*8 +: 8];
			end
		end
	end

	assign intr = intr_reg;
endmodule

// >>> logic/parallel_io_port_decode.sv
module parallel_io_port_decode
	import pio_pkg::*;
#(
	parameter int BOARD_IRQS = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// unit reset, high active
	input wire logic unit_reset_in,
	// cpu address and cycle qualifiers
	input wire logic [15:0] cpu_addr,
	input wire logic io_cycle,
	input wire logic int_ack_n,
	// cpu strobes
	input wire logic io_read_strobe_n,
	input wire logic io_write_strobe_n,
	// host data bus
	input wire logic [7:0] host_data_bus_in,
	output logic [7:0] host_data_bus_out,
	output logic host_data_bus_oe_n,
	// decoded selects
	output logic unit0_select_n,
	output logic unit1_select_n,
	output logic module_select0_n,
	output logic module_select1_n,
	// first unit pins
	input wire logic [pio_pkg::UNIT_PORT_BITS-1:0] unit0_pins_in,
	output logic [pio_pkg::UNIT_PORT_BITS-1:0] unit0_pins_out,
	output logic [pio_pkg::UNIT_PORT_BITS-1:0] unit0_pins_oe_n,
	input wire logic unit0_strobe_n,
	// second unit pins
	input wire logic [pio_pkg::UNIT_PORT_BITS-1:0] unit1_pins_in,
	output logic [pio_pkg::UNIT_PORT_BITS-1:0] unit1_pins_out,
	output logic [pio_pkg::UNIT_PORT_BITS-1:0] unit1_pins_oe_n,
	// interrupt sources
	input wire logic [BOARD_IRQS-1:0] board_irq,
	input wire logic [1:0] ext_irq,
	input wire logic module_irq1,
	input wire logic module_irq2,
	input wire logic [1:0] module_irq_en,
	output logic cpu_irq
);
	import pio_pkg::*;

	unit_bus_if bus0 ();
	unit_bus_if bus1 ();

	logic [1:0] decode_memory [64];
	logic [1:0] decode_bits;
	logic [7:0] io_addr;
	logic io_ok;

	// sampled pins
	logic [7:0] addr_s_reg, addr_s_next;
	logic sel0_s_reg, sel0_s_next;
	logic sel1_s_reg, sel1_s_next;
	logic rd_s_reg, rd_s_next;
	logic wr_s_reg, wr_s_next;
	logic [7:0] din_s_reg, din_s_next;

	// cycle tracking
	cycle_state_t state_reg, state_next;
	logic unit1_cyc_reg, unit1_cyc_next;
	logic [1:0] wsel_reg, wsel_next;
	logic [7:0] wdata_reg, wdata_next;
	logic commit0, commit1;

	// outputs
	logic [7:0] dout_reg, dout_next;
	logic oe_n_reg, oe_n_next;
	logic sel0_n_reg, sel0_n_next;
	logic sel1_n_reg, sel1_n_next;
	logic msel0_n_reg, msel0_n_next;
	logic msel1_n_reg, msel1_n_next;
	logic irq_reg, irq_next;
	logic unit0_intr, unit1_intr;

	// decode memory contents: one word per four-address block
	always_comb begin
		for (int i = 0; i < 64; i++) begin
			decode_memory[i] = DECODE_NONE;
		end
		decode_memory[UNIT0_PORT_A_DATA[7:2]] = DECODE_UNIT0; // [R1]
		decode_memory[UNIT1_PORT_A_DATA[7:2]] = DECODE_UNIT1; // [R2]
	end

	// i/o port number sits on the low byte
	assign io_addr = cpu_addr[7:0];
	assign decode_bits = decode_memory[io_addr[7:2]];
	// acknowledge cycles must never select a unit
	assign io_ok = io_cycle && int_ack_n;

	always_comb begin
		sel0_n_next = ~(io_ok && cpu_addr[15] && decode_bits[0]); // [R8]
		sel1_n_next = ~(io_ok && cpu_addr[15] && decode_bits[1]); // [R8]
		msel0_n_next = ~(io_ok && io_addr[7:3] == MODULE0_FIRST[7:3]); // [R10]
		msel1_n_next = ~(io_ok && io_addr[7:3] == MODULE1_FIRST[7:3]); // [R10]
		// equal-priority wired merge
		irq_next = (|board_irq) || (|ext_irq) || unit0_intr || unit1_intr
			|| (module_irq1 && module_irq_en[0]) || (module_irq2 && module_irq_en[1]); // [R9]
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sel0_n_reg <= 1'b1;
			sel1_n_reg <= 1'b1;
			msel0_n_reg <= 1'b1;
			msel1_n_reg <= 1'b1;
			irq_reg <= 1'b0;
		end else begin
			sel0_n_reg <= sel0_n_next;
			sel1_n_reg <= sel1_n_next;
			msel0_n_reg <= msel0_n_next;
			msel1_n_reg <= msel1_n_next;
			irq_reg <= irq_next;
		end
	end

	// the unit sees the registered select plus sampled address and strobes
	always_comb begin
		addr_s_next = io_addr;
		sel0_s_next = sel0_n_reg;
		sel1_s_next = sel1_n_reg;
		rd_s_next = io_read_strobe_n;
		wr_s_next = io_write_strobe_n;
		din_s_next = host_data_bus_in;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			addr_s_reg <= 8'h00_00;
			sel0_s_reg <= 1'b1;
			sel1_s_reg <= 1'b1;
			rd_s_reg <= 1'b1;
			wr_s_reg <= 1'b1;
			din_s_reg <= 8'h00_00;
		end else begin
			addr_s_reg <= addr_s_next; // [R11]
			sel0_s_reg <= sel0_s_next;
			sel1_s_reg <= sel1_s_next;
			rd_s_reg <= rd_s_next;
			wr_s_reg <= wr_s_next;
			din_s_reg <= din_s_next;
		end
	end

	always_comb begin
		state_next = state_reg;
		unit1_cyc_next = unit1_cyc_reg;
		wsel_next = wsel_reg;
		wdata_next = wdata_reg;
		commit0 = 1'b0;
		commit1 = 1'b0;
		case (state_reg)
			CYC_IDLE: begin
				if (!sel0_s_reg || !sel1_s_reg) begin // [R2]
					unit1_cyc_next = !sel1_s_reg;
					wsel_next = addr_s_reg[1:0];
					wdata_next = din_s_reg;
					if (!wr_s_reg) begin
						state_next = CYC_WRITE;
					end else if (!rd_s_reg) begin
						state_next = CYC_READ;
					end
				end
			end
			CYC_WRITE: begin
				// keep the latest byte; data may settle late in the strobe
				if (!wr_s_reg) begin
					wdata_next = din_s_reg;
				end else begin
					commit0 = !unit1_cyc_reg; // [R11]
					commit1 = unit1_cyc_reg; // [R11]
					state_next = CYC_IDLE;
				end
			end
			CYC_READ: begin
				if (rd_s_reg || (sel0_s_reg && sel1_s_reg)) begin
					state_next = CYC_IDLE;
				end
			end
			default: begin
				state_next = CYC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= CYC_IDLE;
			unit1_cyc_reg <= 1'b0;
			wsel_reg <= SEL_PORT_A;
			wdata_reg <= 8'h00_00;
		end else begin
			state_reg <= state_next;
			unit1_cyc_reg <= unit1_cyc_next;
			wsel_reg <= wsel_next;
			wdata_reg <= wdata_next;
		end
	end

	always_comb begin
		bus0.wr_commit = commit0;
		bus1.wr_commit = commit1;
		bus0.wr_sel = wsel_reg;
		bus1.wr_sel = wsel_reg;
		bus0.wr_data = wdata_reg;
		bus1.wr_data = wdata_reg;
		bus0.rd_sel = addr_s_reg[1:0]; // [R3]
		bus1.rd_sel = addr_s_reg[1:0]; // [R3]
		// read side effect only once, on entry to the read
		bus0.rd_active = state_reg == CYC_IDLE && state_next == CYC_READ && !sel0_s_reg;
		bus1.rd_active = state_reg == CYC_IDLE && state_next == CYC_READ && !sel1_s_reg;
		bus0.unit_reset = unit_reset_in; // [R5]
		bus1.unit_reset = unit_reset_in; // [R5]
	end

	// data bus drive; control address is never driven, as its read is illegal
	always_comb begin
		dout_next = dout_reg;
		oe_n_next = 1'b1;
		if (!rd_s_reg && addr_s_reg[1:0] != SEL_CONTROL) begin // [R3]
			if (!sel0_s_reg) begin // [R4]
				dout_next = bus0.rd_data;
				oe_n_next = 1'b0;
			end else if (!sel1_s_reg) begin // [R4]
				dout_next = bus1.rd_data;
				oe_n_next = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dout_reg <= 8'h00_00;
			oe_n_reg <= 1'b1;
		end else begin
			dout_reg <= dout_next;
			oe_n_reg <= oe_n_next;
		end
	end

	parallel_io_unit #(.FULL_MODES(1'b1)) first_parallel_unit ( // [R6]
		.clk(clk),
		.rst_n(rst_n),
		.bus(bus0),
		.pins_in(unit0_pins_in),
		.pins_out(unit0_pins_out),
		.pins_oe_n(unit0_pins_oe_n),
		.strobe_n(unit0_strobe_n),
		.intr(unit0_intr)
	);

	parallel_io_unit #(.FULL_MODES(1'b0)) second_parallel_unit ( // [R7]
		.clk(clk),
		.rst_n(rst_n),
		.bus(bus1),
		.pins_in(unit1_pins_in),
		.pins_out(unit1_pins_out),
		.pins_oe_n(unit1_pins_oe_n),
		.strobe_n(1'b1),
		.intr(unit1_intr)
	);

	assign host_data_bus_out = dout_reg;
	assign host_data_bus_oe_n = oe_n_reg;
	assign unit0_select_n = sel0_n_reg;
	assign unit1_select_n = sel1_n_reg;
	assign module_select0_n = msel0_n_reg;
	assign module_select1_n = msel1_n_reg;
	assign cpu_irq = irq_reg;
endmodule

// >>> sim/parallel_io_port_decode_properties.sv
module decode_checker
	import pio_pkg::*;
#(
	parameter int BOARD_IRQS = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic unit_reset_in,
	// cpu side
	input wire logic [15:0] cpu_addr,
	input wire logic io_cycle,
	input wire logic int_ack_n,
	input wire logic host_data_bus_oe_n,
	// selects
	input wire logic unit0_select_n,
	input wire logic unit1_select_n,
	input wire logic module_select0_n,
	input wire logic module_select1_n,
	// pins and interrupts
	input wire logic [UNIT_PORT_BITS-1:0] unit0_pins_oe_n,
	input wire logic [BOARD_IRQS-1:0] board_irq,
	input wire logic cpu_irq
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic qual;
	assign qual = io_cycle && int_ack_n;
	chk_unit0_decode: assert property (qual && cpu_addr[15] && cpu_addr[7:2] == 6'h39 |=> !unit0_select_n)
		else $error("unit0 select missing");
	chk_unit1_decode: assert property (qual && cpu_addr[15] && cpu_addr[7:2] == 6'h3A |=> !unit1_select_n)
		else $error("unit1 select missing");
	chk_ack_blocks: assert property (!int_ack_n |=> unit0_select_n && unit1_select_n && module_select0_n)
		else $error("select during acknowledge");
	chk_module_low: assert property (qual && cpu_addr[7:3] == 5'h1E |=> !module_select0_n && module_select1_n)
		else $error("module select 0 wrong");
	chk_module_high: assert property (qual && cpu_addr[7:3] == 5'h1F |=> module_select0_n && !module_select1_n)
		else $error("module select 1 wrong");
	chk_ctl_noread: assert property ((cpu_addr[1:0] == 2'h3) [*3] |-> host_data_bus_oe_n)
		else $error("control register drove the bus");
	chk_unit_reset: assert property (unit_reset_in |=> &unit0_pins_oe_n)
		else $error("unit reset left an output");
	chk_irq_merge: assert property (|board_irq |=> cpu_irq)
		else $error("board interrupt not merged");
	cover property (!host_data_bus_oe_n);
	cover property (!module_select1_n);
	cover property ($fell(cpu_irq));
endmodule

bind parallel_io_port_decode decode_checker #(.BOARD_IRQS(BOARD_IRQS)) i_props (.clk(clk), .rst_n(rst_n),
	.unit_reset_in(unit_reset_in), .cpu_addr(cpu_addr), .io_cycle(io_cycle), .int_ack_n(int_ack_n),
	.host_data_bus_oe_n(host_data_bus_oe_n), .unit0_select_n(unit0_select_n), .unit1_select_n(unit1_select_n),
	.module_select0_n(module_select0_n), .module_select1_n(module_select1_n),
	.unit0_pins_oe_n(unit0_pins_oe_n), .board_irq(board_irq), .cpu_irq(cpu_irq));

// >>> sim/cpu_bus_model.sv
module cpu_bus_model (
	// clock
	input wire logic clk,
	// device answer
	input wire logic [7:0] bus_out,
	input wire logic bus_oe_n,
	// cycle lines
	output logic [15:0] cpu_addr,
	output logic io_cycle,
	output logic int_ack_n,
	output logic rd_n,
	output logic wr_n,
	output logic [7:0] wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cpu_addr = 16'h0000;
		io_cycle = 1'b1;
		int_ack_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		wdata = 8'h5A;
	end
	task automatic lines(input logic [15:0] a, input logic io, input logic ack);
		@(posedge clk);
		cpu_addr <= a;
		io_cycle <= io;
		int_ack_n <= ack;
		repeat (3) @(posedge clk);
	endtask
	// hold sets prompt or slow strobe length
	task automatic cyc(input logic [15:0] a, input logic wr, input logic [7:0] d, input int hold,
		output logic [7:0] q, output logic drv);
		drv = 1'b0;
		q = 8'h00;
		lines(a, 1'b1, 1'b1);
		if (wr) begin
			wr_n <= 1'b0;
			wdata <= d;
		end else begin
			rd_n <= 1'b0;
		end
		repeat (hold) begin
			@(posedge clk);
			if (!wr && !bus_oe_n) begin
				q = bus_out;
				drv = 1'b1;
			end
		end
		wr_n <= 1'b1;
		rd_n <= 1'b1;
		// released bus shows a changed value, not the last byte
		wdata <= ~d;
		repeat (5) @(posedge clk);
	endtask
endmodule

// >>> sim/parallel_io_port_decode_tb.sv
module parallel_io_port_decode_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, ureset, stb_n, mirq1, mirq2, oe_n, s0, s1, m0, m1, irq, rd_n, wr_n, io, ack, drv;
	logic [1:0] birq, eirq, men;
	logic [7:0] lf, dout, wdata, q;
	logic [15:0] addr;
	logic [23:0] pin0, pin1, o0, e0, o1, e1;
	int err_total, n_checks, u, p, i;
	int lat[6];
	int ctl[2];
	logic [15:0] ta[8] = '{16'h80E5, 16'h80EA, 16'h00E5, 16'h80E5, 16'h80E5, 16'h80F3, 16'h00FA, 16'h80F8};
	logic [1:0] tq[8] = '{2'h3, 2'h3, 2'h3, 2'h1, 2'h2, 2'h3, 2'h3, 2'h2};
	logic [3:0] te[8] = '{4'h7, 4'hB, 4'hF, 4'hF, 4'hF, 4'hD, 4'hE, 4'hF};
	cpu_bus_model i_cpu (.clk(clk), .bus_out(dout), .bus_oe_n(oe_n), .cpu_addr(addr), .io_cycle(io),
		.int_ack_n(ack), .rd_n(rd_n), .wr_n(wr_n), .wdata(wdata));
	parallel_io_port_decode i_dut (.clk(clk), .rst_n(rst_n), .unit_reset_in(ureset), .cpu_addr(addr),
		.io_cycle(io), .int_ack_n(ack), .io_read_strobe_n(rd_n), .io_write_strobe_n(wr_n),
		.host_data_bus_in(!oe_n ? dout : wdata), .host_data_bus_out(dout), .host_data_bus_oe_n(oe_n),
		.unit0_select_n(s0), .unit1_select_n(s1), .module_select0_n(m0), .module_select1_n(m1),
		.unit0_pins_in(pin0), .unit0_pins_out(o0), .unit0_pins_oe_n(e0), .unit0_strobe_n(stb_n),
		.unit1_pins_in(pin1), .unit1_pins_out(o1), .unit1_pins_oe_n(e1), .board_irq(birq), .ext_irq(eirq),
		.module_irq1(mirq1), .module_irq2(mirq2), .module_irq_en(men), .cpu_irq(irq));
	function automatic logic [7:0] rnd();
		lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
		return lf;
	endfunction
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		if (err_total == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input int un, input int pt, input logic [7:0] d);
		i_cpu.cyc(16'h80E4 + 16'(4 * un + pt), 1'b1, d, 4, q, drv);
		if (pt == 3)
			ctl[un] = int'(d);
		else
			lat[un * 3 + pt] = int'(d);
	endtask
	task automatic rd(input int un, input int pt);
		i_cpu.cyc(16'h80E4 + 16'(4 * un + pt), 1'b0, 8'h00, 4 + 4 * pt, q, drv);
	endtask
	task automatic ports();
		for (int k = 0; k < 2; k++) begin
			chk(k ? o1 : o0, 24'({lat[k * 3 + 2][7:0], lat[k * 3 + 1][7:0], lat[k * 3][7:0]}));
			chk(k ? e1 : e0, {{8{~ctl[k][2]}}, {8{~ctl[k][1]}}, {8{~ctl[k][0]}}});
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (50000) @(posedge clk);
		err_total++;
		final_report();
	end
	initial begin
		// reset low, unit reset idle, strobe at its idle high level
		{rst_n, ureset, stb_n, mirq1, mirq2, birq, eirq, men, pin0, pin1} = {3'h1, 56'h0};
		lf = 8'h24;
		lat = '{default: 0};
		ctl = '{default: 0};
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		ports();
		for (u = 0; u < 2; u++) begin
			wr(u, 3, 8'h07);
			for (p = 0; p < 3; p++) wr(u, p, rnd());
			ports();
			for (p = 0; p < 3; p++) begin
				rd(u, p);
				chk({drv, q}, {1'b1, lat[u * 3 + p][7:0]});
			end
			rd(u, 3);
			chk(drv, 1'b0);
			wr(u, 3, 8'h00);
			@(posedge clk);
			{pin1, pin0} <= {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
			for (p = 0; p < 3; p++) begin
				rd(u, p);
				chk({drv, q}, {1'b1, u ? pin1[8 * p +: 8] : pin0[8 * p +: 8]});
			end
		end
		wr(0, 3, 8'h08);
		stb_n <= 1'b0;
		@(posedge clk);
		stb_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk(irq, 1'b1);
		wr(0, 0, rnd());
		chk(irq, 1'b0);
		// last pass raises module source 1 with its enable off
		for (i = 0; i < 7; i++) begin
			@(posedge clk);
			{mirq2, mirq1, eirq, birq} <= (i == 6) ? 6'h10 : 6'(1 << i);
			men <= (i == 6) ? 2'h2 : 2'h3;
			repeat (3) @(posedge clk);
			chk(irq, (i != 6));
			{mirq2, mirq1, eirq, birq} <= 6'h00;
			repeat (3) @(posedge clk);
			chk(irq, 1'b0);
		end
		for (i = 0; i < 8; i++) begin
			i_cpu.lines(ta[i], tq[i][1], tq[i][0]);
			chk({s0, s1, m0, m1}, te[i]);
		end
		wr(1, 3, 8'h1F);
		wr(1, 1, rnd());
		ports();
		ureset <= 1'b1;
		@(posedge clk);
		ureset <= 1'b0;
		repeat (2) @(posedge clk);
		lat = '{default: 0};
		ctl = '{default: 0};
		ports();
		final_report();
	end
endmodule
